// [asbp_host.sv]
// host controller driving an asynchronous byte-wide static memory
//
// Notes on behaviour
// - new read address no faster than read cycle
// - select read: oe, strobe, address held stable
// - strobe write ends on strobe rising
// - wait float delay before driving write data
// - select write ends when select deasserts
`timescale 1ns/1ps
module asbp_host #(
   parameter int ADDR_W = asbp_pkg::ADDR_W,
   parameter int DATA_W = asbp_pkg::DATA_W
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // user request
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic              req_select_style,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   req_ready,
   // user answer
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   // memory pins
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   mem_select_low_active_n,
   output logic                   mem_select_high_active,
   output logic                   mem_write_strobe_n,
   output logic                   mem_output_enable_n,
   output logic [DATA_W-1:0]      mem_dq_out,
   output logic                   mem_dq_oe,
   input  wire logic [DATA_W-1:0] mem_dq_in
);
   // widths must match the memory geometry
   if (ADDR_W != asbp_pkg::ADDR_W || DATA_W != asbp_pkg::DATA_W) begin : g_chk
      $error("asbp_host: widths must match the memory geometry");
   end

   typedef enum logic [2:0] {
      ASBP_IDLE,
      ASBP_RD_ACCESS,
      ASBP_RD_HOLD,
      ASBP_WR_FLOAT,
      ASBP_WR_PULSE,
      ASBP_WR_END,
      ASBP_RECOVER
   } asbp_state_t;

   asbp_state_t                      state_ff;     // sequencer state
   logic [asbp_pkg::CNT_W-1:0]       cnt_ff;       // cycles left in a phase
   logic [ADDR_W-1:0]                addr_ff;      // address held for the cycle
   logic [DATA_W-1:0]                wdata_ff;     // write data held for the cycle
   asbp_pkg::asbp_wstyle_t           style_ff;     // how the write ends
   logic                             sel_ff;       // both selects asserted
   logic                             strobe_ff;    // write strobe asserted
   logic                             oe_ff;        // output enable asserted
   logic                             drive_ff;     // host drives the data bus
   logic                             capture_ff;   // sample read data next edge
   logic                             ready_ff;     // accept a request

   asbp_pins_if pins ();

   // phase lengths sized to the counter
   function automatic logic [asbp_pkg::CNT_W-1:0] len(input int c);
      return asbp_pkg::CNT_W'(c - 1);
   endfunction : len

   // sequencer: one access at a time, each with its pin phases timed
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ASBP_IDLE;
         cnt_ff   <= '0;
      end else begin
         unique case (state_ff)
            ASBP_IDLE: begin
               if (req_valid && ready_ff) begin
                  // writes start with the strobe, float wait before data
                  state_ff <= req_write ? ASBP_WR_FLOAT : ASBP_RD_ACCESS;
                  cnt_ff   <= req_write ? len(asbp_pkg::FLOAT_CYC)
                                        : len(asbp_pkg::ACCESS_CYC + 1);
               end
            end
            ASBP_RD_ACCESS: begin
               // pins stand still until the slowest access has elapsed
               if (cnt_ff == '0) begin
                  state_ff <= ASBP_RD_HOLD;
                  cnt_ff   <= '0;
               end else begin
                  cnt_ff <= cnt_ff - 1'b1;
               end
            end
            ASBP_RD_HOLD: begin
               state_ff <= ASBP_RECOVER;
               cnt_ff   <= len(asbp_pkg::RECOV_CYC);
            end
            ASBP_WR_FLOAT: begin
               if (cnt_ff == '0) begin
                  state_ff <= ASBP_WR_PULSE;
                  cnt_ff   <= len(asbp_pkg::PULSE_CYC > asbp_pkg::SETUP_CYC ?
                                  asbp_pkg::PULSE_CYC : asbp_pkg::SETUP_CYC);
               end else begin
                  cnt_ff <= cnt_ff - 1'b1;
               end
            end
            ASBP_WR_PULSE: begin
               if (cnt_ff == '0) begin
                  state_ff <= ASBP_WR_END;
               end else begin
                  cnt_ff <= cnt_ff - 1'b1;
               end
            end
            ASBP_WR_END: begin
               // data held one more edge: zero hold after the ending edge
               state_ff <= ASBP_RECOVER;
               cnt_ff   <= len(asbp_pkg::READ_CYC);
            end
            ASBP_RECOVER: begin
               if (cnt_ff == '0) begin
                  state_ff <= ASBP_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 1'b1;
               end
            end
            default: begin
               state_ff <= ASBP_IDLE;
            end
         endcase
      end
   end

   // request capture: address and data frozen for the whole access
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_ff  <= '0;
         wdata_ff <= '0;
         style_ff <= asbp_pkg::ASBP_WR_STROBE;
      end else if (state_ff == ASBP_IDLE && req_valid && ready_ff) begin
         addr_ff  <= req_addr;
         wdata_ff <= req_wdata;
         style_ff <= req_select_style ? asbp_pkg::ASBP_WR_SELECT : asbp_pkg::ASBP_WR_STROBE;
      end
   end

   // select pins: asserted for the whole access, dropped to end a select write
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_ff <= 1'b0;
      end else if (state_ff == ASBP_IDLE) begin
         sel_ff <= req_valid && ready_ff;
      end else if (state_ff == ASBP_WR_PULSE && cnt_ff == '0
                   && style_ff == asbp_pkg::ASBP_WR_SELECT) begin
         sel_ff <= 1'b0;
      end else if (state_ff == ASBP_WR_END || state_ff == ASBP_RD_HOLD) begin
         sel_ff <= 1'b0;
      end
   end

   // write strobe: falls first, rises to end a strobe write
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_ff <= 1'b0;
      end else if (state_ff == ASBP_IDLE) begin
         strobe_ff <= req_valid && ready_ff && req_write;
      end else if (state_ff == ASBP_WR_PULSE && cnt_ff == '0) begin
         strobe_ff <= style_ff == asbp_pkg::ASBP_WR_SELECT;
      end else if (state_ff == ASBP_WR_END) begin
         strobe_ff <= 1'b0;
      end
   end

   // output enable: only for reads, held with the selects
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_ff <= 1'b0;
      end else if (state_ff == ASBP_IDLE) begin
         oe_ff <= req_valid && ready_ff && !req_write;
      end else if (state_ff == ASBP_RD_HOLD) begin
         oe_ff <= 1'b0;
      end
   end

   // bus drive: only after the memory has floated, kept through the end edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_ff <= 1'b0;
      end else if (state_ff == ASBP_WR_FLOAT && cnt_ff == '0) begin
         drive_ff <= 1'b1;
      end else if (state_ff == ASBP_WR_END) begin
         drive_ff <= 1'b0;
      end
   end

   // read capture: pins lag one flop, so sample one edge after hold entry
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         capture_ff <= 1'b0;
         rsp_valid  <= 1'b0;
         rsp_rdata  <= '0;
      end else begin
         capture_ff <= state_ff == ASBP_RD_ACCESS && cnt_ff == '0;
         rsp_valid  <= capture_ff;
         if (capture_ff) begin
            rsp_rdata <= mem_dq_in;
         end
      end
   end

   // ready only when idle and no request taken this edge; spacing meets cycle time
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_ff <= 1'b0;
      end else begin
         ready_ff <= (state_ff == ASBP_IDLE && !(req_valid && ready_ff))
                     || (state_ff == ASBP_RECOVER && cnt_ff == '0);
      end
   end
   assign req_ready = ready_ff;

   // pin bundle; the memory itself needs no clock, only these levels
   assign pins.addr     = addr_ff;
   assign pins.wdata    = wdata_ff;
   assign pins.sel_n    = !sel_ff;
   assign pins.sel_h    = sel_ff;
   assign pins.strobe_n = !strobe_ff;
   assign pins.oe_n     = !oe_ff;
   assign pins.drive    = drive_ff;

   // pin flops
   asbp_pin_reg u_pins (
      .sys_clk                 (sys_clk),
      .rst_n                   (rst_n),
      .pins                    (pins),
      .mem_addr                (mem_addr),
      .mem_select_low_active_n (mem_select_low_active_n),
      .mem_select_high_active  (mem_select_high_active),
      .mem_strobe_n            (mem_write_strobe_n),
      .mem_oe_n                (mem_output_enable_n),
      .mem_dq_out              (mem_dq_out),
      .mem_dq_oe               (mem_dq_oe)
   );
endmodule : asbp_host

// [asbp_host_monitor.sv]
// assertion checker watching the host controller memory pins
`timescale 1ns/1ps
module asbp_host_monitor #(
   parameter int ADDR_W = 17,
   parameter int DATA_W = 8
) (
   // clock, reset and answer
   input wire logic              sys_clk,
   input wire logic              rst_n,
   input wire logic              rsp_valid,
   // memory pins
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_select_low_active_n,
   input wire logic              mem_write_strobe_n,
   input wire logic              mem_output_enable_n,
   input wire logic              mem_dq_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // one cycle of the write strobe held low
   sequence strobe_low_s; !mem_write_strobe_n; endsequence
   // output enable opening a read
   sequence read_open_s; $fell(mem_output_enable_n); endsequence
   // data only after the memory has had a cycle to float
   float_wait_a: assert property ($rose(mem_dq_oe) |-> !$past(mem_write_strobe_n))
      else $error("write data driven before strobe float wait");
   no_clash_a: assert property (mem_dq_oe |-> mem_output_enable_n)
      else $error("host drives bus while output enable low");
   read_hold_a: assert property (!mem_output_enable_n && !$past(mem_output_enable_n)
      |-> $stable(mem_addr) && mem_write_strobe_n && !mem_select_low_active_n)
      else $error("read cycle controls not held");
   read_span_a: assert property (read_open_s |-> !mem_output_enable_n[*2])
      else $error("read shorter than minimum cycle");
   read_answer_a: assert property (read_open_s |-> ##3 rsp_valid)
      else $error("read answer late or missing");
   pulse_width_a: assert property ($fell(mem_write_strobe_n) |-> strobe_low_s[*2])
      else $error("write strobe pulse too short");
   data_setup_a: assert property ($rose(mem_write_strobe_n) |-> $past(mem_dq_oe))
      else $error("strobe rose without write data on bus");
   sel_end_a: assert property ($rose(mem_select_low_active_n) && !$past(mem_write_strobe_n)
      |-> $past(mem_dq_oe))
      else $error("select ended write without data");
   addr_hold_a: assert property (strobe_low_s[*2] |-> $stable(mem_addr))
      else $error("address moved during write");
endmodule : asbp_host_monitor

bind asbp_host asbp_host_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (
   .sys_clk(sys_clk), .rst_n(rst_n), .rsp_valid(rsp_valid), .mem_addr(mem_addr),
   .mem_select_low_active_n(mem_select_low_active_n), .mem_write_strobe_n(mem_write_strobe_n),
   .mem_output_enable_n(mem_output_enable_n), .mem_dq_oe(mem_dq_oe));

// [asbp_pin_reg.sv]
// output flops for every memory pin so the pins come straight from registers
`timescale 1ns/1ps
module asbp_pin_reg (
   // clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         rst_n,
   // from sequencer
   asbp_pins_if.drv                          pins,
   // to memory pins
   output logic [asbp_pkg::ADDR_W-1:0]       mem_addr,
   output logic                              mem_select_low_active_n,
   output logic                              mem_select_high_active,
   output logic                              mem_strobe_n,
   output logic                              mem_oe_n,
   output logic [asbp_pkg::DATA_W-1:0]       mem_dq_out,
   output logic                              mem_dq_oe
);
   // all pins idle: deselected, strobe and enable high, bus released
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_addr                <= '0;
         mem_select_low_active_n <= 1'b1;
         mem_select_high_active  <= 1'b0;
         mem_strobe_n            <= 1'b1;
         mem_oe_n                <= 1'b1;
         mem_dq_out              <= '0;
         mem_dq_oe               <= 1'b0;
      end else begin
         mem_addr                <= pins.addr;
         mem_select_low_active_n <= pins.sel_n;
         mem_select_high_active  <= pins.sel_h;
         mem_strobe_n            <= pins.strobe_n;
         mem_oe_n                <= pins.oe_n;
         mem_dq_out              <= pins.wdata;
         mem_dq_oe               <= pins.drive;
      end
   end
endmodule : asbp_pin_reg

// [asbp_pins_if.sv]
// memory pin bundle between the sequencer and the pin driver
`timescale 1ns/1ps
interface asbp_pins_if;
   logic [asbp_pkg::ADDR_W-1:0] addr;      // address
   logic [asbp_pkg::DATA_W-1:0] wdata;     // write data
   logic                        sel_n;     // low-active select
   logic                        sel_h;     // high-active select
   logic                        strobe_n;  // write strobe
   logic                        oe_n;      // output enable
   logic                        drive;     // data bus drive request
   modport seq (output addr, wdata, sel_n, sel_h, strobe_n, oe_n, drive);
   modport drv (input  addr, wdata, sel_n, sel_h, strobe_n, oe_n, drive);
endinterface : asbp_pins_if

// [asbp_pkg.sv]
// constants for the byte-wide static memory host controller
package asbp_pkg;
   // geometry of the memory
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int WORDS  = 131072;
   // clock period in picoseconds (25 MHz)
   localparam int CLK_PS = 40000;
   // pin timings in ns
   localparam int READ_CYCLE_MIN_NS       = 45;
   localparam int ADDRESS_ACCESS_DELAY_NS = 45;
   localparam int SELECT_ACCESS_DELAY_NS  = 45;
   localparam int OE_ACCESS_DELAY_NS      = 15;
   localparam int OE_FLOAT_DELAY_NS       = 15;
   localparam int STROBE_TO_FLOAT_DELAY_NS = 15;
   localparam int STROBE_PULSE_WIDTH_NS   = 35;
   localparam int DATA_SETUP_NS           = 20;
   // least times rounded up to whole cycles, never below one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_up
   localparam int READ_CYC   = cyc_up(READ_CYCLE_MIN_NS);
   localparam int ACCESS_CYC = cyc_up(ADDRESS_ACCESS_DELAY_NS > SELECT_ACCESS_DELAY_NS ?
                                      ADDRESS_ACCESS_DELAY_NS : SELECT_ACCESS_DELAY_NS);
   localparam int FLOAT_CYC  = cyc_up(STROBE_TO_FLOAT_DELAY_NS);
   localparam int PULSE_CYC  = cyc_up(STROBE_PULSE_WIDTH_NS);
   localparam int SETUP_CYC  = cyc_up(DATA_SETUP_NS);
   localparam int RECOV_CYC  = cyc_up(OE_FLOAT_DELAY_NS);
   localparam int CNT_W      = 4;
   // write styles
   typedef enum logic {
      ASBP_WR_STROBE,
      ASBP_WR_SELECT
   } asbp_wstyle_t;
endpackage : asbp_pkg

// [asbp_sram_model.sv]
// behavioural byte-wide static memory on the far side of the pins
`timescale 1ns/1ps
module asbp_sram_model (
   // pins from the host
   input  wire logic [16:0] addr,
   input  wire logic        sel_n,
   input  wire logic        sel_h,
   input  wire logic        strobe_n,
   input  wire logic        oe_n,
   input  wire logic [7:0]  host_dq,
   input  wire logic        host_dq_oe,
   // slow answers take the full access delay
   input  wire logic        slow,
   // resolved bus level
   output logic [7:0]       bus_dq
);
   logic [7:0]  mem [131072];      // storage, no clock used
   logic [7:0]  last_dq = 8'h00;   // last driven level
   logic [16:0] seen_addr;         // address the timer follows
   time         t_start = 0;       // start of current access
   logic        out_on = 1'b0;     // memory drives the bus
   // mode decode; anything else floats the bus
   wire rd_en = !sel_n && sel_h && strobe_n && !oe_n;
   wire wr_en = !sel_n && sel_h && !strobe_n;
   // access timer restarts on address or mode change
   always #1 begin
      if (!rd_en || addr !== seen_addr) begin
         t_start = $time;
         seen_addr = addr;
      end
      out_on = rd_en && ($time - t_start >= (slow ? 45 : 5));
      if (out_on || host_dq_oe)
         last_dq = bus_dq;
   end
   // both driving gives unknown; floating shows the inverse, not a stale byte
   assign bus_dq = host_dq_oe ? (out_on ? 8'hxx : host_dq) : (out_on ? mem[addr] : ~last_dq);
   // byte taken when strobe or a select ends the write
   always @(negedge wr_en) mem[addr] = bus_dq;
endmodule : asbp_sram_model

// [tb_asbp_host.sv]
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
module tb_asbp_host;
   logic        sys_clk = 1'b0;           // 25 MHz clock
   logic        rst_n = 1'b0;             // reset, active low
   logic        req_valid = 1'b0;         // request strobe
   logic        req_write = 1'b0;         // write when high
   logic        req_select_style = 1'b0;  // select-ended write
   logic [16:0] req_addr = 17'h00000;     // byte address
   logic [7:0]  req_wdata = 8'h00;        // write byte
   logic        slow = 1'b0;              // slow memory answers
   logic        req_ready, rsp_valid, sel_n, sel_h, strobe_n, oe_n, dq_oe;
   logic [7:0]  rsp_rdata, dq_out, dq_in;
   logic [16:0] mem_addr;
   logic [7:0]  exp_mem [logic [16:0]];   // reference contents
   logic [16:0] used [$];                 // addresses written so far
   logic [15:0] seed_ff = 16'h5b0b;       // lfsr state
   int          errors = 0;
   int          num_checks = 0;
   always #20 sys_clk = ~sys_clk;
   asbp_host dut (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_write(req_write), .req_select_style(req_select_style), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_select_low_active_n(sel_n),
      .mem_select_high_active(sel_h), .mem_write_strobe_n(strobe_n),
      .mem_output_enable_n(oe_n), .mem_dq_out(dq_out), .mem_dq_oe(dq_oe), .mem_dq_in(dq_in));
   asbp_sram_model u_mem (.addr(mem_addr), .sel_n(sel_n), .sel_h(sel_h), .strobe_n(strobe_n),
      .oe_n(oe_n), .host_dq(dq_out), .host_dq_oe(dq_oe), .slow(slow), .bus_dq(dq_in));
   // next pseudo-random state
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // byte a read should return
   function automatic logic [7:0] expected(input logic [16:0] a);
      return exp_mem.exists(a) ? exp_mem[a] : 8'hxx;
   endfunction : expected
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [16:0] seen, input logic [16:0] want);
      num_checks++;
      if (seen !== want) begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : chk
   // bounded wait that ends the run when it runs dry
   task automatic give_up(input int n);
      if (n >= 60) begin
         errors++;
         $display("CHECK FAILED at %0t: handshake timeout", $time);
         give_verdict();
      end
   endtask : give_up
   // pins in standby while reset holds
   task automatic chk_idle;
      chk(sel_n, 1'b1);
      chk(sel_h, 1'b0);
      chk(oe_n, 1'b1);
      chk(strobe_n, 1'b1);
      chk(dq_oe, 1'b0);
   endtask : chk_idle
   // one request; ab resets the block two cycles after it is taken
   task automatic req(input logic wr, input logic sty, input logic [16:0] a,
                      input logic [7:0] d, input logic ab);
      int n;
      n = 0;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_select_style <= sty;
      req_addr <= a;
      req_wdata <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 60);
      give_up(n);
      req_valid <= 1'b0;
      if (wr) begin
         exp_mem[a] = d;
         used.push_back(a);
      end
      if (ab) begin
         repeat (2) @(posedge sys_clk);
         rst_n <= 1'b0;
      end else if (!wr) begin
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (rsp_valid !== 1'b1 && n < 60);
         give_up(n);
         chk(rsp_rdata, expected(a));
         @(posedge sys_clk);
         chk(rsp_valid, 1'b0);
      end
   endtask : req
   initial begin
      repeat (5) @(posedge sys_clk);
      chk_idle();
      chk(req_ready, 1'b0);
      rst_n <= 1'b1;
      // both address ends, both write styles, read back
      for (int s = 0; s < 2; s++) begin
         req(1'b1, s[0], 17'h00000, 8'ha5 ^ s[7:0], 1'b0);
         req(1'b1, s[0], 17'h1ffff, 8'h5a ^ s[7:0], 1'b0);
         req(1'b0, 1'b0, 17'h00000, 8'h00, 1'b0);
         req(1'b0, 1'b0, 17'h1ffff, 8'h00, 1'b0);
      end
      $display("test corners done");
      // back-to-back overwrite, last byte must win
      req(1'b1, 1'b0, 17'h00155, 8'h11, 1'b0);
      req(1'b1, 1'b1, 17'h00155, 8'hee, 1'b0);
      req(1'b0, 1'b0, 17'h00155, 8'h00, 1'b0);
      $display("test overwrite done");
      // random mix, memory answering fast or slow
      for (int i = 0; i < 60; i++) begin
         seed_ff = lfsr(seed_ff);
         slow <= seed_ff[0];
         if (seed_ff[1])
            req(1'b1, seed_ff[4], {seed_ff[2], seed_ff}, seed_ff[12:5], 1'b0);
         else
            req(1'b0, 1'b0, used[seed_ff[9:3] % used.size()], 8'h00, 1'b0);
      end
      $display("test random done");
      // reset in mid-read, then the block must work again
      req(1'b0, 1'b0, 17'h00155, 8'h00, 1'b1);
      @(posedge sys_clk);
      chk_idle();
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      req(1'b0, 1'b0, 17'h00155, 8'h00, 1'b0);
      $display("test reset done");
      give_verdict();
   end
endmodule : tb_asbp_host
